// [rx_sigdet_pkg.sv]
package rx_sigdet_pkg;

  // ----------------------------------------------------------------------
  // Tick generator for the preamble counting clock.
  // ----------------------------------------------------------------------
  // Phase accumulator width and increments giving twice the filter clock
  // (758, 379, 189, 94.8, 47.4, 23.7 kHz) from the 25 MHz system clock.
  localparam int TICK_ACC_W = 24;
  localparam logic [23:0] TICK_INC_758K = 24'hf8622;
  localparam logic [23:0] TICK_INC_379K = 24'h7c311;
  localparam logic [23:0] TICK_INC_189K = 24'h3e189;
  localparam logic [23:0] TICK_INC_95K = 24'h1f0c4;
  localparam logic [23:0] TICK_INC_47K = 24'hf862;
  localparam logic [23:0] TICK_INC_24K = 24'h7c31;

  // ----------------------------------------------------------------------
  // Signal level and noise interval.
  // ----------------------------------------------------------------------
  // Samples per interval for interval code 0; each code step doubles it.
  localparam logic [7:0] NOISE_BASE_SAMPLES = 8'h10;
  // Noise added over a full interval of high-frequency input.
  localparam logic [7:0] HF_FULL_ADD = 8'h51;
  // Log2 of the base sample count.
  localparam logic [2:0] NOISE_BASE_LOG2 = 3'h4;

  // ----------------------------------------------------------------------
  // Preamble judgement.
  // ----------------------------------------------------------------------
  localparam logic [2:0] PRE_HIT_BASE = 3'h3;
  localparam logic [2:0] PRE_MISS_LIMIT = 3'h3;
  localparam int PRE_CNT_W = 10;

  // ----------------------------------------------------------------------
  // Peak hold shift bases, ASK low-pass shift and peak reset value.
  // ----------------------------------------------------------------------
  localparam logic [3:0] PEAK_CHARGE_SHIFT_BASE = 4'h1;
  localparam logic [3:0] PEAK_DISCH_SHIFT_BASE = 4'h4;
  localparam logic [2:0] LPF_SHIFT = 3'h2;
  localparam logic [15:0] PEAK_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Configuration carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [8:0] preamble_target_count;
    logic [6:0] preamble_tolerance;
    logic edge_mode;
    logic [1:0] hit_count_sel;
  } preamble_cfg_t;

  typedef struct packed {
    logic level_enable;
    logic [7:0] level_threshold;
    logic noise_enable;
    logic hf_add_enable;
    logic [5:0] noise_threshold;
    logic [1:0] level_noise_interval;
  } level_noise_cfg_t;

  typedef struct packed {
    logic ask_select;
    logic quick_charge_two;
    logic [1:0] peak_charge_coeff;
    logic [2:0] peak_discharge_coeff;
    logic [3:0] bitrate_filter_cutoff;
  } demod_cfg_t;

endpackage

// [peak_hold_tracker.sv]
`timescale 1ns/1ns
// Exponential peak follower: fast charge while the input is above the
// held level, slow discharge while below. Fraction bits keep small steps.
module peak_hold_tracker (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Filter clock tick and sample.
  input wire logic i_tick,
  input wire logic [7:0] i_sample,
  // Coefficients.
  input wire logic [1:0] i_charge_coeff,
  input wire logic [2:0] i_discharge_coeff,
  // Held peak, integer part.
  output logic [7:0] o_peak
);
  import rx_sigdet_pkg::*;

  logic [15:0] peak_ff; // Held level with eight fraction bits.
  logic [15:0] nxt_peak; // Next held level.
  wire [15:0] in_ext = {i_sample, 8'h00}; // Input in the same format.
  wire rising = in_ext >= peak_ff; // Charging when input is not below.
  wire [15:0] diff = rising ? (in_ext - peak_ff) : (peak_ff - in_ext);
  wire [3:0] sh_tp = PEAK_CHARGE_SHIFT_BASE + {2'h0, i_charge_coeff};
  wire [3:0] sh_tr = PEAK_DISCH_SHIFT_BASE + {1'h0, i_discharge_coeff};
  wire [16:0] step_charge = {1'b0, diff >> sh_tp} + {1'b0, diff >> sh_tr};
  wire [15:0] step_disch = diff >> sh_tr;

  // Charge rate is the sum of both rates, so the charge time constant is
  // the parallel combination of the two coefficients; never overshoots.
  always_comb begin
    nxt_peak = peak_ff;
    if (i_tick) begin
      if (rising) begin
        nxt_peak = peak_ff + step_charge[15:0];
      end else begin
        nxt_peak = peak_ff - step_disch;
      end
    end
  end

  // Held level register.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      peak_ff <= PEAK_RESET;
    end else begin
      peak_ff <= nxt_peak;
    end
  end

  assign o_peak = peak_ff[15:8];
endmodule

// [rx_signal_detect_peak_hold.sv]
`timescale 1ns/1ns
module rx_signal_detect_peak_hold (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Configuration.
  input wire rx_sigdet_pkg::preamble_cfg_t i_preamble_cfg,
  input wire rx_sigdet_pkg::level_noise_cfg_t i_level_noise_cfg,
  input wire rx_sigdet_pkg::demod_cfg_t i_demod_cfg,
  input wire logic i_test_mode,
  // Demodulator data path.
  input wire logic i_comparator_out,
  input wire logic i_sample_strobe,
  input wire logic [7:0] i_signal_level,
  input wire logic [7:0] i_noise_level,
  input wire logic i_high_freq,
  input wire logic [7:0] i_ask_adc_code,
  input wire logic [7:0] i_filter_out,
  // Judgement pins.
  output logic o_monitor_pin_one,
  output logic o_monitor_pin_two,
  // Test observation.
  output logic o_test_level_hit,
  output logic o_test_noise_hit,
  output logic o_test_preamble_hit,
  // Monitors and ASK level.
  output logic [7:0] o_noise_level_monitor,
  output logic [7:0] o_peak_level_monitor,
  output logic [7:0] o_ask_filtered_level
);
  import rx_sigdet_pkg::*;

  // ----------------------------------------------------------------------
  // Counting clock tick
  // ----------------------------------------------------------------------

  logic [TICK_ACC_W-1:0] tick_acc_ff; // Phase accumulator.
  logic tick_ff; // One cycle per count clock period.
  logic fbc_phase_ff; // Halves the count tick to the filter clock.
  logic [23:0] tick_inc; // Increment chosen by the cutoff code.
  wire [2:0] cut_idx = i_demod_cfg.bitrate_filter_cutoff[3:1];
  wire [TICK_ACC_W:0] tick_sum = {1'b0, tick_acc_ff} + {1'b0, tick_inc};
  wire fbc_tick = tick_ff & fbc_phase_ff; // Filter clock tick.

  // Filter clock steps by pairs of cutoff codes; the top codes fold back.
  always_comb begin
    unique case (cut_idx)
      3'h0: tick_inc = TICK_INC_758K;
      3'h1: tick_inc = TICK_INC_379K;
      3'h2: tick_inc = TICK_INC_189K;
      3'h3: tick_inc = TICK_INC_95K;
      3'h4: tick_inc = TICK_INC_47K;
      3'h5: tick_inc = TICK_INC_24K;
      default: tick_inc = TICK_INC_758K;
    endcase
  end

  // Carry out of the accumulator is the count tick at twice fbc.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_acc_ff <= '0;
      tick_ff <= 1'b0;
      fbc_phase_ff <= 1'b0;
    end else begin
      tick_acc_ff <= tick_sum[TICK_ACC_W-1:0];
      tick_ff <= tick_sum[TICK_ACC_W];
      fbc_phase_ff <= fbc_phase_ff ^ tick_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Comparator synchroniser and edges
  // ----------------------------------------------------------------------

  logic comp_meta_ff; // First stage, read only by the second.
  logic comp_sync_ff; // Second stage.
  logic comp_prev_ff; // Previous synchronised level.

  // Two stages, then one more for the edge detector.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
      comp_prev_ff <= 1'b0;
    end else begin
      comp_meta_ff <= i_comparator_out;
      comp_sync_ff <= comp_meta_ff;
      comp_prev_ff <= comp_sync_ff;
    end
  end

  wire rise_edge = comp_sync_ff & ~comp_prev_ff;
  wire any_edge = comp_sync_ff ^ comp_prev_ff;
  // Edge mode 0 measures rising to rising, mode 1 between opposite edges.
  wire period_edge = i_preamble_cfg.edge_mode ? any_edge : rise_edge;

  // ----------------------------------------------------------------------
  // Preamble period classification
  // ----------------------------------------------------------------------

  logic [PRE_CNT_W-1:0] per_cnt_ff; // Ticks since the last qualifying edge.
  logic overrun_ff; // Current period already judged too long.
  logic [2:0] hit_run_ff; // Consecutive in-tolerance periods.
  logic [2:0] miss_run_ff; // Consecutive out-of-tolerance periods.
  logic pre_present_ff; // Preamble detector says present.
  logic pre_absent_ff; // Preamble detector says absent.

  // Half target in edge mode 1 drops the odd bit.
  wire [8:0] pre_target = i_preamble_cfg.edge_mode ?
    {1'b0, i_preamble_cfg.preamble_target_count[8:1]} :
    i_preamble_cfg.preamble_target_count;
  // The margin is never scaled with the target.
  wire [PRE_CNT_W-1:0] tol_ext = {3'h0, i_preamble_cfg.preamble_tolerance};
  wire [PRE_CNT_W-1:0] tgt_ext = {1'b0, pre_target};
  wire [PRE_CNT_W-1:0] win_hi = tgt_ext + tol_ext;
  wire [PRE_CNT_W-1:0] win_lo = (tgt_ext > tol_ext) ?
    (tgt_ext - tol_ext) : '0;
  wire in_window = (per_cnt_ff >= win_lo) && (per_cnt_ff <= win_hi);
  wire too_long = (per_cnt_ff > win_hi) && !overrun_ff;
  wire period_hit = period_edge && !overrun_ff && in_window;
  wire period_miss = (period_edge && !overrun_ff && !in_window) ||
    too_long;
  wire [2:0] hit_need = PRE_HIT_BASE + {1'b0, i_preamble_cfg.hit_count_sel};
  wire [2:0] hit_run_inc = (hit_run_ff == hit_need) ? hit_run_ff :
    hit_run_ff + 3'h1;
  wire [2:0] miss_run_inc = (miss_run_ff == PRE_MISS_LIMIT) ? miss_run_ff :
    miss_run_ff + 3'h1;
  wire [PRE_CNT_W-1:0] per_cnt_inc = (&per_cnt_ff) ? per_cnt_ff :
    per_cnt_ff + {{(PRE_CNT_W-1){1'b0}}, 1'b1};

  // Period counter: cleared on each qualifying edge, counts count ticks.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      per_cnt_ff <= '0;
      overrun_ff <= 1'b0;
    end else if (!i_preamble_cfg.enable || period_edge) begin
      per_cnt_ff <= '0;
      overrun_ff <= 1'b0;
    end else begin
      // A period too long is judged once, then waits for the next edge.
      if (too_long) begin
        overrun_ff <= 1'b1;
      end
      if (tick_ff) begin
        per_cnt_ff <= per_cnt_inc;
      end
    end
  end

  // Runs of hits and misses; a hit breaks a miss run and the reverse.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hit_run_ff <= '0;
      miss_run_ff <= '0;
    end else if (!i_preamble_cfg.enable) begin
      hit_run_ff <= '0;
      miss_run_ff <= '0;
    end else if (period_hit) begin
      hit_run_ff <= hit_run_inc;
      miss_run_ff <= '0;
    end else if (period_miss) begin
      miss_run_ff <= miss_run_inc;
      hit_run_ff <= '0;
    end
  end

  // Preamble judgement flags; neither holds while the detector is off.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_present_ff <= 1'b0;
      pre_absent_ff <= 1'b0;
    end else if (!i_preamble_cfg.enable) begin
      pre_present_ff <= 1'b0;
      pre_absent_ff <= 1'b0;
    end else if (period_hit && hit_run_inc == hit_need) begin
      pre_present_ff <= 1'b1;
      pre_absent_ff <= 1'b0;
    end else if (period_miss && miss_run_inc == PRE_MISS_LIMIT) begin
      pre_present_ff <= 1'b0;
      pre_absent_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Level and noise interval
  // ----------------------------------------------------------------------

  logic [7:0] samp_cnt_ff; // Samples taken in this interval.
  logic [7:0] hf_cnt_ff; // Samples with high-frequency input.
  logic lvl_present_ff; // Level detector says present.
  logic lvl_absent_ff; // Level detector says absent.
  logic noise_present_ff; // Noise detector says present.
  logic noise_absent_ff; // Noise detector says absent.
  logic [7:0] noise_mon_ff; // Noise level with correction.

  wire [1:0] nint = i_level_noise_cfg.level_noise_interval;
  wire [7:0] samp_last = (NOISE_BASE_SAMPLES << nint) - 8'h01;
  wire interval_end = i_sample_strobe && (samp_cnt_ff == samp_last);
  wire [7:0] hf_next = hf_cnt_ff + {7'h0, i_high_freq};
  // Share of the interval with high frequency, scaled to the full amount.
  // Depends on no IF detector or high-frequency detector setting.
  wire [15:0] hf_prod = {8'h00, hf_next} * {8'h00, HF_FULL_ADD};
  wire [2:0] hf_shift = NOISE_BASE_LOG2 + {1'b0, nint};
  wire [15:0] hf_scaled = hf_prod >> hf_shift;
  wire [7:0] hf_add = i_level_noise_cfg.hf_add_enable ?
    hf_scaled[7:0] : 8'h00;
  // Measured noise only counts while noise detection is on.
  wire [7:0] noise_meas = i_level_noise_cfg.noise_enable ?
    i_noise_level : 8'h00;
  wire [8:0] noise_sum = {1'b0, noise_meas} + {1'b0, hf_add};
  wire [7:0] noise_total = noise_sum[8] ? 8'hff : noise_sum[7:0];
  wire [7:0] noise_thr = {i_level_noise_cfg.noise_threshold, 2'b00};
  wire ask_mode = i_demod_cfg.ask_select;
  // Noise path can give absent with either function on, but present
  // only with noise detection itself on; it gives neither in ASK.
  wire noise_path_on = (i_level_noise_cfg.noise_enable ||
    i_level_noise_cfg.hf_add_enable) && !ask_mode;
  wire noise_can_hit = i_level_noise_cfg.noise_enable && !ask_mode;
  wire lvl_above = i_signal_level > i_level_noise_cfg.level_threshold;

  // Sample and high-frequency counters over one interval.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_cnt_ff <= '0;
      hf_cnt_ff <= '0;
    end else if (interval_end) begin
      samp_cnt_ff <= '0;
      hf_cnt_ff <= '0;
    end else if (i_sample_strobe) begin
      samp_cnt_ff <= samp_cnt_ff + 8'h01;
      hf_cnt_ff <= hf_next;
    end
  end

  // Level judgement, one decision per interval; same in FSK and ASK.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lvl_present_ff <= 1'b0;
      lvl_absent_ff <= 1'b0;
    end else if (!i_level_noise_cfg.level_enable) begin
      lvl_present_ff <= 1'b0;
      lvl_absent_ff <= 1'b0;
    end else if (interval_end) begin
      lvl_present_ff <= lvl_above;
      lvl_absent_ff <= !lvl_above;
    end
  end

  // Noise judgement: low noise means signal, high noise means none.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      noise_present_ff <= 1'b0;
      noise_absent_ff <= 1'b0;
      noise_mon_ff <= '0;
    end else if (!noise_path_on) begin
      noise_present_ff <= 1'b0;
      noise_absent_ff <= 1'b0;
    end else if (interval_end) begin
      noise_mon_ff <= noise_total;
      noise_present_ff <= noise_can_hit && (noise_total < noise_thr);
      noise_absent_ff <= noise_total >= noise_thr;
    end else if (!noise_can_hit) begin // Drop a stale present at once.
      noise_present_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // ASK level path
  // ----------------------------------------------------------------------

  logic [7:0] adc_ff; // Digitised signal strength.
  logic [15:0] lpf_ff; // Low-pass state with eight fraction bits.
  logic [7:0] ask_out_ff; // Limited level toward the comparator.
  logic [7:0] peak_level; // Held peak from the tracker.
  wire [15:0] adc_ext = {adc_ff, 8'h00};
  wire [15:0] lpf_up = (adc_ext - lpf_ff) >> LPF_SHIFT;
  wire [15:0] lpf_dn = (lpf_ff - adc_ext) >> LPF_SHIFT;
  wire [7:0] lpf_level = lpf_ff[15:8];
  // Floor sits at half the held peak.
  wire [7:0] limit_floor = {1'b0, peak_level[7:1]};
  wire limiter_on = ask_mode && i_demod_cfg.quick_charge_two;
  wire [7:0] limited = (limiter_on && lpf_level < limit_floor) ?
    limit_floor : lpf_level;

  // The code is captured first, then filtered; idle outside ASK.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adc_ff <= '0;
      lpf_ff <= '0;
      ask_out_ff <= '0;
    end else if (ask_mode) begin
      adc_ff <= i_ask_adc_code;
      lpf_ff <= (adc_ext >= lpf_ff) ? lpf_ff + lpf_up :
        lpf_ff - lpf_dn;
      ask_out_ff <= limited;
    end
  end

  // Peak follower on the bit-rate filter output at the filter clock.
  peak_hold_tracker u_peak (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_tick(fbc_tick && ask_mode),
    .i_sample(i_filter_out),
    .i_charge_coeff(i_demod_cfg.peak_charge_coeff),
    .i_discharge_coeff(i_demod_cfg.peak_discharge_coeff),
    .o_peak(peak_level)
  );

  // ----------------------------------------------------------------------
  // Overall judgement and outputs
  // ----------------------------------------------------------------------

  wire any_present = lvl_present_ff | noise_present_ff | pre_present_ff;
  // Absent needs every active detector absent and at least one active.
  wire lvl_ok = !i_level_noise_cfg.level_enable || lvl_absent_ff;
  wire noise_ok = !noise_path_on || noise_absent_ff;
  wire pre_ok = !i_preamble_cfg.enable || pre_absent_ff;
  wire any_on = i_level_noise_cfg.level_enable || noise_path_on ||
    i_preamble_cfg.enable;
  wire all_absent = any_on && lvl_ok && noise_ok && pre_ok && !any_present;

  // Output registers.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_monitor_pin_one <= 1'b0;
      o_monitor_pin_two <= 1'b0;
      o_test_level_hit <= 1'b0;
      o_test_noise_hit <= 1'b0;
      o_test_preamble_hit <= 1'b0;
      o_noise_level_monitor <= '0;
      o_peak_level_monitor <= '0;
      o_ask_filtered_level <= '0;
    end else begin
      o_monitor_pin_one <= any_present;
      o_monitor_pin_two <= all_absent;
      o_test_level_hit <= i_test_mode & lvl_present_ff;
      o_test_noise_hit <= i_test_mode & noise_present_ff;
      o_test_preamble_hit <= i_test_mode & pre_present_ff;
      o_noise_level_monitor <= noise_mon_ff;
      o_peak_level_monitor <= peak_level;
      o_ask_filtered_level <= ask_out_ff;
    end
  end
endmodule

// [rx_sigdet_checker.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Port-level checks on the signal detect block.
// ---------------------------------------------------------------------
module rx_sigdet_checker
  import rx_sigdet_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Watched inputs.
  input wire rx_sigdet_pkg::preamble_cfg_t i_preamble_cfg,
  input wire rx_sigdet_pkg::level_noise_cfg_t i_level_noise_cfg,
  input wire rx_sigdet_pkg::demod_cfg_t i_demod_cfg,
  input wire logic i_test_mode,
  input wire logic i_sample_strobe,
  // Watched outputs.
  input wire logic o_monitor_pin_one,
  input wire logic o_monitor_pin_two,
  input wire logic o_test_level_hit,
  input wire logic o_test_noise_hit,
  input wire logic o_test_preamble_hit,
  input wire logic [7:0] o_noise_level_monitor,
  input wire logic [7:0] o_peak_level_monitor
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Preamble detector held off long enough for its flag to clear.
  sequence pre_off_s;
    !i_preamble_cfg.enable [*3];
  endsequence
  // Test observation switched off for two edges.
  sequence test_off_s;
    !i_test_mode [*2];
  endsequence
  reset_quiet_a: assert property ($rose(i_reset_n) |->
    !o_monitor_pin_one && !o_monitor_pin_two) else $error("pins not idle");
  pins_apart_a: assert property (!(o_monitor_pin_one &&
    o_monitor_pin_two)) else $error("both judgement pins high");
  test_gate_a: assert property (test_off_s |-> !(o_test_level_hit ||
    o_test_noise_hit || o_test_preamble_hit)) else $error("test out high");
  noise_quiet_a: assert property (!i_level_noise_cfg.noise_enable [*3]
    |-> !o_test_noise_hit) else $error("noise present while disabled");
  ask_no_noise_a: assert property (i_demod_cfg.ask_select [*3]
    |-> !o_test_noise_hit) else $error("noise present in ASK");
  mon_change_a: assert property ($changed(o_noise_level_monitor)
    |-> $past(i_sample_strobe, 2)) else $error("noise monitor moved");
  peak_still_a: assert property (!i_demod_cfg.ask_select [*3]
    |-> $stable(o_peak_level_monitor)) else $error("peak moved in FSK");
  pre_off_a: assert property (pre_off_s |-> !o_test_preamble_hit)
    else $error("preamble present while disabled");
endmodule

bind rx_signal_detect_peak_hold rx_sigdet_checker rx_sigdet_checker_inst (
  .i_clock, .i_reset_n, .i_preamble_cfg, .i_level_noise_cfg, .i_demod_cfg,
  .i_test_mode, .i_sample_strobe, .o_monitor_pin_one, .o_monitor_pin_two,
  .o_test_level_hit, .o_test_noise_hit, .o_test_preamble_hit,
  .o_noise_level_monitor, .o_peak_level_monitor);

// [demod_partner.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Demodulator side model: sample strobes, comparator periods, ASK data.
// ---------------------------------------------------------------------
module demod_partner (
  // Clock.
  input wire logic i_clock,
  // Datapath toward the block.
  output logic o_comparator_out = 1'b0,
  output logic o_sample_strobe = 1'b0,
  output logic o_high_freq = 1'b0,
  output logic [7:0] o_signal_level = 8'h00,
  output logic [7:0] o_noise_level = 8'h00,
  output logic [7:0] o_ask_adc_code = 8'h00,
  output logic [7:0] o_filter_out = 8'h00
);
  // Sends n back-to-back samples, the first hf of them at high frequency.
  task automatic interval(input int n, input int hf, input logic [7:0] lvl,
                          input logic [7:0] nse);
    for (int i = 0; i < n; i++) begin
      o_sample_strobe = 1'b1;
      o_high_freq = (i < hf);
      o_signal_level = lvl;
      o_noise_level = nse;
      @(posedge i_clock);
      #2;
    end
    // Idle data is scrambled so a stale value is never mistaken for news.
    o_sample_strobe = 1'b0;
    o_high_freq = ~o_high_freq;
    o_signal_level = ~lvl;
    o_noise_level = ~nse;
  endtask
  // Sends n comparator periods, each high then low for half cycles.
  task automatic periods(input int n, input int half);
    repeat (n) begin
      o_comparator_out = 1'b1;
      repeat (half) @(posedge i_clock);
      #2;
      o_comparator_out = 1'b0;
      repeat (half) @(posedge i_clock);
      #2;
    end
  endtask
  // Sets the filter output and the converter code.
  task automatic set_ask(input logic [7:0] f, input logic [7:0] a);
    o_filter_out = f;
    o_ask_adc_code = a;
  endtask
endmodule

// [tb_rx_signal_detect_peak_hold.sv]
`timescale 1ns/1ns
module tb_rx_signal_detect_peak_hold;
  import rx_sigdet_pkg::*;
  // ---------------------------------------------------------------------
  // Stimulus and observed signals.
  // ---------------------------------------------------------------------
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  preamble_cfg_t pc = '0;
  level_noise_cfg_t lc = '0;
  demod_cfg_t dc = '0;
  logic test_mode = 1'b0;
  logic cmp, strobe, hf, pin_one, pin_two, lvl_hit, nse_hit, pre_hit;
  logic [7:0] lvl, nse, adc, filt, nse_mon, peak_mon, ask_lvl;
  int error_cnt = 0;
  int compares = 0;
  // A 25 MHz clock.
  always #20 i_clock = ~i_clock;
  rx_signal_detect_peak_hold rx_signal_detect_peak_hold_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_preamble_cfg(pc),
    .i_level_noise_cfg(lc), .i_demod_cfg(dc), .i_test_mode(test_mode),
    .i_comparator_out(cmp), .i_sample_strobe(strobe), .i_signal_level(lvl),
    .i_noise_level(nse), .i_high_freq(hf), .i_ask_adc_code(adc),
    .i_filter_out(filt), .o_monitor_pin_one(pin_one),
    .o_monitor_pin_two(pin_two), .o_test_level_hit(lvl_hit),
    .o_test_noise_hit(nse_hit), .o_test_preamble_hit(pre_hit),
    .o_noise_level_monitor(nse_mon), .o_peak_level_monitor(peak_mon),
    .o_ask_filtered_level(ask_lvl));
  demod_partner demod_partner_inst (
    .i_clock(i_clock), .o_comparator_out(cmp), .o_sample_strobe(strobe),
    .o_high_freq(hf), .o_signal_level(lvl), .o_noise_level(nse),
    .o_ask_adc_code(adc), .o_filter_out(filt));
  // Waits n edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  // Compares one value and counts the result.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge i_clock);
    error_cnt++;
    final_report();
  end
  // ---------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------
  initial begin
    tick(5);
    i_reset_n = 1'b1;
    tick(1);
    check({pin_one, pin_two}, 8'h00);
    test_mode = 1'b1;
    lc.level_enable = 1'b1;
    lc.level_threshold = 8'h40;
    demod_partner_inst.interval(16, 0, 8'h80, 8'h00);
    tick(3);
    check({lvl_hit, pin_one, pin_two}, 8'h06);
    demod_partner_inst.interval(16, 0, 8'h20, 8'h00);
    tick(3);
    check({lvl_hit, pin_one, pin_two}, 8'h01);
    lc.level_enable = 1'b0;
    lc.hf_add_enable = 1'b1;
    // Half and full high-frequency intervals at two interval lengths.
    for (int c = 0; c < 2; c++) begin
      lc.level_noise_interval = 2'(c);
      demod_partner_inst.interval(16 << c, 8 << c, 8'h00, 8'h30);
      tick(3);
      check(nse_mon, 8'h28);
      demod_partner_inst.interval(16 << c, 16 << c, 8'h00, 8'h30);
      tick(3);
      check(nse_mon, 8'h51);
      check({nse_hit, pin_two}, 16'h0001);
    end
    lc.level_noise_interval = 2'h0;
    lc.noise_enable = 1'b1;
    lc.hf_add_enable = 1'b0;
    lc.noise_threshold = 6'h10;
    demod_partner_inst.interval(16, 0, 8'h00, 8'h20);
    tick(3);
    check({nse_mon, nse_hit, pin_one}, {6'h00, 8'h20, 2'h3});
    dc.ask_select = 1'b1;
    demod_partner_inst.interval(16, 0, 8'h00, 8'h30);
    tick(3);
    check({nse_hit, nse_mon}, {8'h00, 8'h20});
    dc.ask_select = 1'b0;
    lc.noise_enable = 1'b0;
    // Target of 10 ticks at twice the filter clock, margin of 2.
    pc.preamble_target_count = 9'h00a;
    pc.preamble_tolerance = 7'h02;
    for (int s = 0; s < 4; s += 3) begin
      pc.enable = 1'b0;
      pc.hit_count_sel = 2'(s);
      tick(3);
      pc.enable = 1'b1; // Detector back on with its hit and miss runs cleared.
      demod_partner_inst.periods(3 + s, 82);
      check(pre_hit, 8'h00);
      demod_partner_inst.periods(1, 82);
      check({pre_hit, pin_one}, 8'h03);
    end
    demod_partner_inst.periods(4, 250);
    check({pre_hit, pin_two}, 8'h01);
    pc.enable = 1'b0;
    tick(3);
    // Odd target 21 in opposite-edge mode halves to 10 ticks.
    pc.edge_mode = 1'b1;
    pc.preamble_target_count = 9'h015;
    pc.hit_count_sel = 2'h0;
    pc.enable = 1'b1;
    demod_partner_inst.periods(3, 165);
    check(pre_hit, 8'h01);
    pc.enable = 1'b0;
    // Charge coefficient kept far below the discharge coefficient.
    dc.ask_select = 1'b1;
    dc.peak_discharge_coeff = 3'h7;
    demod_partner_inst.set_ask(8'hc0, 8'h00);
    tick(3000);
    check(peak_mon >= 8'hb8, 8'h01);
    demod_partner_inst.set_ask(8'h00, 8'h00);
    tick(200);
    check(peak_mon >= 8'hb0, 8'h01);
    dc.quick_charge_two = 1'b1;
    tick(100);
    check(ask_lvl >= 8'h58, 8'h01);
    dc.quick_charge_two = 1'b0;
    tick(100);
    check(ask_lvl < 8'h08, 8'h01);
    dc.ask_select = 1'b0;
    test_mode = 1'b0;
    tick(3);
    check({lvl_hit, nse_hit, pre_hit}, 8'h00);
    final_report();
  end
endmodule
